// File: core/pcap_pkg.sv
// Shared constants for the power-management capability field block.
// Assumes a 32-bit APB slave port with a 12-bit byte address.
package pcap_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CAP_W = 16;

  // Register index as printed, byte address is four times the index
  localparam logic [ADDR_W-1:0] CAP_REG_IDX = 12'h0046;
  localparam logic [ADDR_W-1:0] CAP_REG_ADDR = 12'h0118;
  // Local control and status words next to the capability word
  localparam logic [ADDR_W-1:0] CTRL_REG_ADDR = 12'h011C;
  localparam logic [ADDR_W-1:0] WSTAT_REG_ADDR = 12'h0120;

  // Field positions inside the capability word
  localparam int COLD_BIT = 15;
  localparam int WAKE_MSB = 14;
  localparam int WAKE_LSB = 11;
  localparam int DEEP_BIT = 10;
  localparam int LIGHT_BIT = 9;
  localparam int AUX_MSB = 8;
  localparam int AUX_LSB = 6;
  localparam int INIT_BIT = 5;
  localparam int RESERVED_BIT_BIT = 4;
  localparam int LOWER_MSB = 3;

  // Field values
  localparam logic [3:0] WAKE_MASK_RST = 4'hF;
  localparam logic [2:0] AUX_SELF = 3'h0;
  localparam logic [2:0] AUX_55MA = 3'h1;
  localparam logic [3:0] LOWER_VAL = 4'h2;

  // Control word layout and reset value
  localparam int CTRL_COLD_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

  // Ignored-write status layout
  localparam int WSTAT_CNT_W = 8;
  localparam int WSTAT_SEEN_BIT = 8;

  typedef enum logic [1:0] {
    PCAP_IDLE,
    PCAP_SETUP,
    PCAP_ACCESS
  } pcap_state_e;

endpackage : pcap_pkg

// File: core/pcap_field_gen.sv
// Builds the 16-bit capability word from the cold-wake flag.
// Assumes the flag is a registered level on the same clock.
`timescale 1ns/1ps
module pcap_field_gen (
  input wire logic cold_wake_flag,
  output logic [pcap_pkg::CAP_W-1:0] cap_word
);
  import pcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Every field is constant except bit 15 and the standby-current code
  always_comb begin
    cap_word = '0;
    cap_word[COLD_BIT] = cold_wake_flag;
    cap_word[WAKE_MSB:WAKE_LSB] = WAKE_MASK_RST;
    cap_word[DEEP_BIT] = 1'b1;
    cap_word[LIGHT_BIT] = 1'b1;
    cap_word[AUX_MSB:AUX_LSB] = cold_wake_flag ? AUX_55MA : AUX_SELF;
    cap_word[INIT_BIT] = 1'b0;
    cap_word[RESERVED_BIT_BIT] = 1'b0;
    cap_word[LOWER_MSB:0] = LOWER_VAL;
  end

endmodule : pcap_field_gen

// File: core/pcap_regs.sv
// APB slave holding the read-only power-management capability word,
// a control word that sets the cold-wake flag, and a count of writes
// that hit the read-only word.
// Assumes an APB master on clk; all inputs come from the same domain.
//
// Functional notes
// - Wake-state mask reads 1111b.
// - Deep-doze supported bit reads one.
// - Light-doze supported bit reads one.
// - Standby-current code follows cold-wake flag: 000b/001b.
// - Special-initialization flag reads zero.
// - Reserved bit 4 reads zero.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pcap_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pcap_pkg::ADDR_W-1:0] paddr,
  input wire logic [pcap_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pcap_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cold_wake_flag
);
  import pcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // True when the address names one of the three words
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == CAP_REG_ADDR) || (a == CTRL_REG_ADDR) ||
                  (a == WSTAT_REG_ADDR);
  endfunction : addr_mapped

  // True when a write targets the read-only capability word
  function automatic logic hits_cap(input logic [ADDR_W-1:0] a);
    hits_cap = (a == CAP_REG_ADDR);
  endfunction : hits_cap

  ////////////////////////////////////////////////////////////////////////////
  // Capability word, built from the live flag

  logic [CAP_W-1:0] cap_word;

  pcap_field_gen u_field_gen (
    .cold_wake_flag(cold_wake_flag),
    .cap_word(cap_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state

  pcap_state_e state_q;
  pcap_state_e state_d;
  logic setup_cyc;
  logic access_cyc;
  logic wr_fire;
  logic take_cyc;

  // Setup is psel without penable, access completes in the next cycle
  assign setup_cyc = psel && !penable;
  assign access_cyc = psel && penable;
  // Slave never stalls; only an access that follows a setup is taken, so
  // a stray penable without a setup cycle cannot write anything
  assign take_cyc = access_cyc && (state_q == PCAP_SETUP);
  assign wr_fire = take_cyc && pwrite;

  // Next state of the transfer tracker
  always_comb begin
    state_d = state_q;
    case (state_q)
      PCAP_IDLE: begin
        if (setup_cyc) begin
          state_d = PCAP_SETUP;
        end
      end
      PCAP_SETUP: begin
        if (access_cyc) begin
          state_d = PCAP_ACCESS;
        end else if (!psel) begin
          state_d = PCAP_IDLE;
        end
      end
      PCAP_ACCESS: begin
        // A back-to-back transfer opens with a fresh setup cycle
        state_d = setup_cyc ? PCAP_SETUP : PCAP_IDLE;
      end
      default: begin
        state_d = PCAP_IDLE;
      end
    endcase
  end

  // Transfer state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PCAP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word: only bit 0 is kept, the rest reads as zero

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;

  // Byte lane 0 carries the cold-wake flag; other lanes hold nothing
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_fire && (paddr == CTRL_REG_ADDR) && pstrb[0]) begin
      ctrl_d = CTRL_RST;
      ctrl_d[CTRL_COLD_BIT] = pwdata[CTRL_COLD_BIT];
    end
  end

  // Control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign cold_wake_flag = ctrl_q[CTRL_COLD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Ignored-write status: counts writes that landed on the read-only word.
  // The capability fields themselves have no storage, so such a write
  // cannot alter them; the count only makes the event visible.

  logic [WSTAT_CNT_W-1:0] ign_cnt_q;
  logic [WSTAT_CNT_W-1:0] ign_cnt_d;
  logic ign_seen_q;
  logic ign_seen_d;

  // Saturating count so a flood of writes never wraps back to zero
  always_comb begin
    ign_cnt_d = ign_cnt_q;
    ign_seen_d = ign_seen_q;
    if (wr_fire && hits_cap(paddr)) begin
      ign_seen_d = 1'b1;
      if (ign_cnt_q != '1) begin
        ign_cnt_d = ign_cnt_q + WSTAT_CNT_W'(1);
      end
    end
  end

  // Status registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ign_cnt_q <= '0;
      ign_seen_q <= 1'b0;
    end else begin
      ign_cnt_q <= ign_cnt_d;
      ign_seen_q <= ign_seen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: captured in the setup cycle so prdata comes from a flop
  // and is steady through the access cycle.

  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic err_q;
  logic err_d;
  logic [DATA_W-1:0] rd_mux;

  // Word selected by the address; unmapped reads return zero
  always_comb begin
    rd_mux = '0;
    case (paddr)
      CAP_REG_ADDR: begin
        rd_mux[CAP_W-1:0] = cap_word;
      end
      CTRL_REG_ADDR: begin
        rd_mux = ctrl_q;
      end
      WSTAT_REG_ADDR: begin
        rd_mux[WSTAT_CNT_W-1:0] = ign_cnt_q;
        rd_mux[WSTAT_SEEN_BIT] = ign_seen_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Latch read word and error flag on the setup cycle
  always_comb begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup_cyc) begin
      rdata_d = pwrite ? '0 : rd_mux;
      err_d = !addr_mapped(paddr);
    end
  end

  // Answer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: zero-wait answer in the first access cycle

  assign pready = access_cyc;
  assign prdata = rdata_q;
  // Error only qualifies the completing cycle, as APB expects
  assign pslverr = access_cyc && err_q;

endmodule : pcap_regs

// File: verification/pcap_regs_sva.sv
// Checker for the capability word seen on the APB read path.
// Assumes it is bound to pcap_regs and sees only its ports.
`timescale 1ns/1ps
module pcap_regs_sva
  import pcap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic cold_wake_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Setup then access on the capability word
  sequence cap_rd;
    psel && !penable && !pwrite && paddr == CAP_REG_ADDR ##1 psel && penable;
  endsequence
  sequence cap_wr;
    psel && !penable && pwrite && paddr == CAP_REG_ADDR ##1 psel && penable;
  endsequence
  wake_mask_a: assert property (cap_rd |-> prdata[14:11] == WAKE_MASK_RST)
    else $error("wake mask field wrong");
  deep_doze_a: assert property (cap_rd |-> prdata[DEEP_BIT])
    else $error("deep doze bit low");
  light_doze_a: assert property (cap_rd |-> prdata[LIGHT_BIT])
    else $error("light doze bit low");
  aux_code_a: assert property (cap_rd |-> prdata[8:6] == (cold_wake_flag ? AUX_55MA : AUX_SELF))
    else $error("standby code wrong");
  init_flag_a: assert property (cap_rd |-> !prdata[INIT_BIT])
    else $error("init flag set");
  reserved_bit_bit_a: assert property (cap_rd |-> !prdata[RESERVED_BIT_BIT])
    else $error("reserved bit set");
  // A write to the fixed word must leave the flag alone
  ro_write_a: assert property (cap_wr |-> !pslverr ##1 $stable(cold_wake_flag))
    else $error("capability write had effect");
endmodule : pcap_regs_sva
////////////////////////////////////////////////////////////////////////////////
bind pcap_regs pcap_regs_sva u_sva (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .cold_wake_flag);

// File: verification/pcap_regs_tb_top.sv
// Self-checking bench for pcap_regs driven through APB tasks.
// Assumes the zero-wait-state slave and address map of pcap_pkg.
`timescale 1ns/1ps
module pcap_regs_tb_top;
  import pcap_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, cold_wake_flag;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  int miscompares = 0;
  int samples_checked = 0;
  pcap_regs dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cold_wake_flag);
  // 100 MHz clock
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One transfer; an idle edge follows so no signal is assigned twice per step
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    int n;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    if (pready !== 1'h1) begin
      miscompares++;
      conclude();
    end
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic xe);
    logic [31:0] r;
    logic err;
    xfer(1'h0, a, 32'h0000_0000, r, err);
    chk(r, e);
    chk({31'h0000_0000, err}, {31'h0000_0000, xe});
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic err;
    xfer(1'h1, a, d, r, err);
    chk({31'h0000_0000, err}, 32'h0000_0000);
  endtask : wr
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: defaults, ignored writes, flag-driven standby code
  initial begin
    clk = 1'h0; rst_b = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = '0; pwdata = 32'h0000_0000; pstrb = 4'h1;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(CAP_REG_ADDR, 32'h0000_7E02, 1'h0);
    $display("test reset_value done");
    wr(CAP_REG_ADDR, 32'hFFFF_FFFF);
    rd(CAP_REG_ADDR, 32'h0000_7E02, 1'h0);
    $display("test ignored_write done");
    wr(CTRL_REG_ADDR, 32'h0000_0001);
    chk({31'h0000_0000, cold_wake_flag}, 32'h0000_0001);
    rd(CTRL_REG_ADDR, 32'h0000_0001, 1'h0);
    rd(CAP_REG_ADDR, 32'h0000_FE42, 1'h0);
    wr(CAP_REG_ADDR, 32'h0000_0000);
    rd(CAP_REG_ADDR, 32'h0000_FE42, 1'h0);
    wr(CTRL_REG_ADDR, 32'h0000_0000);
    chk({31'h0000_0000, cold_wake_flag}, 32'h0000_0000);
    rd(CAP_REG_ADDR, 32'h0000_7E02, 1'h0);
    // Control write without lane 0 strobe must be dropped
    pstrb <= 4'h0;
    wr(CTRL_REG_ADDR, 32'h0000_0001);
    pstrb <= 4'h1;
    chk({31'h0000_0000, cold_wake_flag}, 32'h0000_0000);
    rd(CAP_REG_ADDR, 32'h0000_7E02, 1'h0);
    $display("test standby_code done");
    rd(WSTAT_REG_ADDR, 32'h0000_0102, 1'h0);
    rd(12'h0FF0, 32'h0000_0000, 1'h1);
    $display("test status_unmapped done");
    conclude();
  end
endmodule : pcap_regs_tb_top
